// File: lcd_controller_host_bus_port_bench.sv
`timescale 1ns/10ps
module lcd_controller_host_bus_port_bench;
  localparam int DW = lhp_pkg::DATA_W;
  localparam int AW = lhp_pkg::ADDR_W;
  localparam logic [1:0] STYLE_UNUSED = 2'h3;
  logic ref_clk, rst, indirectSel, cmdValid, cmdWrite, cmdReady, respValid;
  logic wrValid, rdStrobe, indMode, sawOe, sawLow, sawRd;
  logic [1:0] styleSel;
  logic [AW-1:0] cmdAddr, wrAddr, rdAddr;
  logic [DW-1:0] cmdData, respData, wrData, rdData;
  int n_fail, num_checks, cycles;

  lhp_bus_if lnk ();
  lhp_device lhp_device_i (.ref_clk(ref_clk), .rst(rst), .bus(lnk),
    .wrData(wrData), .wrAddr(wrAddr), .wrValid(wrValid), .rdData(rdData),
    .rdAddr(rdAddr), .rdStrobe(rdStrobe), .indirectMode(indMode));
  lhp_host lhp_host_i (.ref_clk(ref_clk), .rst(rst), .bus(lnk),
    .styleSel(styleSel), .indirectSel(indirectSel), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .respData(respData), .respValid(respValid));
  lhp_bus_checker lhp_bus_checker_i (.ref_clk(ref_clk), .rst(rst),
    .chipSelect_n(lnk.chipSelect_n), .readPin(lnk.readPin),
    .addr_strobe_n(lnk.addr_strobe_n), .waitOut(lnk.waitOut),
    .waitOe(lnk.waitOe), .devDataOe(lnk.devDataOe),
    .bus_style_straps(lnk.bus_style_straps));

  // Free running clock at 250 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Notes any driven wait level; a cycle cap cuts a hang short.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (lnk.waitOe === 1'b1) sawOe <= 1'b1;
    if (lnk.waitOe === 1'b1 && lnk.waitOut === 1'b0) sawLow <= 1'b1;
    if (rdStrobe === 1'b1) sawRd <= 1'b1;
    if (cycles == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Straps are only changed under reset, so synchronisers see clean values.
  task automatic mode(input logic [1:0] s, input logic i);
    styleSel = s;
    indirectSel = i;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 sawOe = 1'b0;
    sawLow = 1'b0;
    sawRd = 1'b0;
  endtask

  // One host command, returning the byte seen on the far side.
  task automatic xfer(input logic w, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, output logic [DW-1:0] got);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdData = d;
    @(posedge ref_clk);
    #1 cmdValid = 1'b0;
    n = 0;
    while ((w ? wrValid : respValid) !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(DW'(n < 100), 8'h01);
    got = w ? wrData : respData;
  endtask

  task automatic test_generic();
    logic [DW-1:0] got;
    mode(lhp_pkg::STYLE_GENERIC, lhp_pkg::MODE_DIRECT);
    check(DW'(indMode), 8'h00);
    xfer(1'b1, 1'b1, 8'ha5, got);
    check(got, 8'ha5);
    check(DW'(wrAddr), 8'h01);
    xfer(1'b1, 1'b0, 8'h3c, got);
    check(got, 8'h3c);
    check(DW'(sawLow), 8'h01);
    check(DW'(sawRd), 8'h00);
    repeat (6) @(posedge ref_clk);
    #1 check(DW'(lnk.waitOe), 8'h00);
    xfer(1'b0, 1'b0, 8'h00, got);
    check(got, 8'h96);
    check(DW'(sawRd), 8'h01);
    check(DW'(rdAddr), 8'h00);
    $display("generic test done");
  endtask

  task automatic test_enable();
    logic [DW-1:0] got;
    mode(lhp_pkg::STYLE_ENABLE_CLOCKED, lhp_pkg::MODE_INDIRECT);
    check(DW'(indMode), 8'h01);
    xfer(1'b1, 1'b0, 8'h81, got);
    check(got, 8'h81);
    xfer(1'b0, 1'b1, 8'h00, got);
    check(got, 8'h96);
    check(DW'(rdAddr), 8'h01);
    check(DW'(sawOe), 8'h00);
    $display("enable clocked test done");
  endtask

  task automatic test_strobe();
    logic [DW-1:0] got;
    mode(lhp_pkg::STYLE_ADDR_STROBE, lhp_pkg::MODE_DIRECT);
    xfer(1'b1, 1'b1, 8'h7e, got);
    check(got, 8'h7e);
    xfer(1'b0, 1'b0, 8'h00, got);
    check(got, 8'h96);
    check(DW'(sawOe), 8'h01);
    repeat (6) @(posedge ref_clk);
    #1 check(DW'(lnk.waitOe), 8'h00);
    $display("address strobe test done");
  endtask

  // Unused style code: the device must ignore the whole command. The host
  // then waits for a handshake that never comes, so this runs last.
  task automatic test_none();
    mode(STYLE_UNUSED, lhp_pkg::MODE_DIRECT);
    cmdValid = 1'b1;
    cmdWrite = 1'b1;
    cmdAddr = 1'b1;
    cmdData = 8'h5a;
    @(posedge ref_clk);
    #1 cmdValid = 1'b0;
    repeat (30) @(posedge ref_clk);
    #1 check(DW'(sawOe), 8'h00);
    check(wrData, 8'h00);
    $display("unused style test done");
  endtask

  // Main sequence; every input has a value at time zero.
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = '0;
    cmdData = '0;
    rdData = 8'h96;
    test_generic();
    test_enable();
    test_strobe();
    test_none();
    give_verdict();
  end
endmodule // lcd_controller_host_bus_port_bench

// File: lhp_bus_checker_sva.sv
`timescale 1ns/10ps
// Watches the host bus between the two ends; straps only change in reset.
module lhp_bus_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Bus pins.
  input wire logic chipSelect_n,
  input wire logic readPin,
  input wire logic addr_strobe_n,
  input wire logic waitOut,
  input wire logic waitOe,
  input wire logic devDataOe,
  input wire logic [1:0] bus_style_straps
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Decoded bus style, shared by the properties below.
  logic gen;
  logic ecl;
  logic ast;
  assign gen = bus_style_straps == lhp_pkg::STYLE_GENERIC;
  assign ecl = bus_style_straps == lhp_pkg::STYLE_ENABLE_CLOCKED;
  assign ast = bus_style_straps == lhp_pkg::STYLE_ADDR_STROBE;

  property p_idle;
    chipSelect_n [*6] |-> !waitOe && !devDataOe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus driven while chip select is high");
  property p_gen_low;
    gen && $rose(waitOe) |-> !waitOut;
  endproperty
  a_gen_low: assert property (p_gen_low)
    else $error("generic wait not low when first driven");
  property p_gen_done;
    gen && waitOe && !waitOut |-> ##[1:8] waitOut;
  endproperty
  a_gen_done: assert property (p_gen_done)
    else $error("generic wait never went inactive");
  property p_gen_rel;
    gen && waitOe && $rose(waitOut) |-> ##[1:20] !waitOe;
  endproperty
  a_gen_rel: assert property (p_gen_rel)
    else $error("generic wait not released");
  property p_as_wait;
    ast && $rose(waitOe) |-> waitOut;
  endproperty
  a_as_wait: assert property (p_as_wait)
    else $error("acknowledge not high when first driven");
  property p_as_rel;
    ast && waitOe && !waitOut |-> ##[1:20] !waitOe;
  endproperty
  a_as_rel: assert property (p_as_rel)
    else $error("acknowledge not released");
  property p_ec_none;
    ecl |-> !waitOe;
  endproperty
  a_ec_none: assert property (p_ec_none)
    else $error("wait driven in enable clocked style");
  property p_rd_oe;
    (gen && readPin) [*4] |-> !devDataOe;
  endproperty
  a_rd_oe: assert property (p_rd_oe)
    else $error("data driven without read strobe");
  property p_as_qual;
    (ast && addr_strobe_n) [*6] |-> !waitOe;
  endproperty
  a_as_qual: assert property (p_as_qual)
    else $error("acknowledge driven without address strobe");
endmodule // lhp_bus_checker

// File: lhp_bus_if.sv
`timescale 1ns/10ps
interface lhp_bus_if;
  logic [lhp_pkg::DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [lhp_pkg::DATA_W-1:0] devData;
  logic devDataOe;
  logic [lhp_pkg::ADDR_W-1:0] addr;
  logic chipSelect_n;
  logic readPin;
  logic writePin;
  logic addr_strobe_n;
  logic waitOut;
  logic waitOe;
  logic [1:0] bus_style_straps;
  logic addressing_mode_strap;

  // Resolved data bus; a bus that nobody drives reads as all ones, so a
  // sample taken while it is released shows up as a wrong byte.
  logic [lhp_pkg::DATA_W-1:0] busData;
  assign busData = devDataOe ? devData :
                   (hostDataOe ? hostData : '1);

  // Resolved wait line; pulled high when nobody drives it.
  logic waitLine;
  assign waitLine = waitOe ? waitOut : 1'b1;

  modport device (
    input busData, addr, chipSelect_n, readPin, writePin, addr_strobe_n,
    input bus_style_straps, addressing_mode_strap,
    output devData, devDataOe, waitOut, waitOe
  );

  modport host (
    input busData, waitLine,
    output hostData, hostDataOe, addr, chipSelect_n, readPin, writePin,
    output addr_strobe_n, bus_style_straps, addressing_mode_strap
  );
endinterface

// File: lhp_device.sv
`timescale 1ns/10ps
module lhp_device (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host bus pins.
  lhp_bus_if.device bus,
  // User side.
  output logic [lhp_pkg::DATA_W-1:0] wrData,
  output logic [lhp_pkg::ADDR_W-1:0] wrAddr,
  output logic wrValid,
  input wire logic [lhp_pkg::DATA_W-1:0] rdData,
  output logic [lhp_pkg::ADDR_W-1:0] rdAddr,
  output logic rdStrobe,
  output logic indirectMode
);

  typedef enum logic [1:0] {
    LHP_IDLE = 2'b00,
    LHP_HOLD = 2'b01,
    LHP_DONE = 2'b10
  } lhp_state_e;

  // Two-flop synchronisers on every pin; stage one is read only by stage two.
  logic [lhp_pkg::DATA_W-1:0] dataS1, dataS2;
  logic [lhp_pkg::ADDR_W-1:0] addrS1, addrS2;
  logic [3:0] ctlS1, ctlS2;
  logic [2:0] strapS1, strapS2;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dataS1 <= lhp_pkg::DATA_RESET;
      dataS2 <= lhp_pkg::DATA_RESET;
      addrS1 <= '0;
      addrS2 <= '0;
      ctlS1 <= 4'hf;
      ctlS2 <= 4'hf;
      strapS1 <= 3'h0;
      strapS2 <= 3'h0;
    end
    else
    begin
      dataS1 <= bus.busData;
      dataS2 <= dataS1;
      addrS1 <= bus.addr;
      addrS2 <= addrS1;
      ctlS1 <= {bus.chipSelect_n, bus.readPin, bus.writePin,
                bus.addr_strobe_n};
      ctlS2 <= ctlS1;
      strapS1 <= {bus.addressing_mode_strap, bus.bus_style_straps};
      strapS2 <= strapS1;
    end
  end

  logic csN, rdP, wrP, asN;
  logic [1:0] style;
  assign csN = ctlS2[3];
  assign rdP = ctlS2[2];
  assign wrP = ctlS2[1];
  assign asN = ctlS2[0];
  assign style = strapS2[1:0];
  assign indirectMode = strapS2[2];

  // Decode of a live transfer per bus style; write direction per style.
  logic active, isWrite, genWrite, genRead;
  always_comb
  begin
    genWrite = !wrP;
    genRead = !rdP;
    active = 1'b0;
    isWrite = 1'b0;
    unique case (style)
      lhp_pkg::STYLE_GENERIC:
      begin
        active = !csN && (genWrite || genRead);
        isWrite = genWrite;
      end
      lhp_pkg::STYLE_ENABLE_CLOCKED:
      begin
        active = !csN && rdP;
        isWrite = !wrP;
      end
      lhp_pkg::STYLE_ADDR_STROBE:
      begin
        active = !csN && !asN && !rdP;
        isWrite = !wrP;
      end
      default:
      begin
        active = 1'b0;
        isWrite = 1'b0;
      end
    endcase
  end

  // Decrement step at the counter's own width, so nothing is padded.
  localparam logic [lhp_pkg::CNT_W-1:0] CNT_ONE =
    {{(lhp_pkg::CNT_W-1){1'b0}}, 1'b1};

  // Transfer sequencer: hold wait, then complete, then release.
  lhp_state_e state, next_state;
  logic [lhp_pkg::CNT_W-1:0] cnt, next_cnt;
  logic wasWrite, next_wasWrite;
  logic [lhp_pkg::DATA_W-1:0] latchData, next_latchData;
  logic [lhp_pkg::ADDR_W-1:0] latchAddr, next_latchAddr;
  logic next_wrValid, next_rdStrobe;
  logic [lhp_pkg::DATA_W-1:0] next_devData;
  logic next_devDataOe, next_waitOut, next_waitOe;
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_wasWrite = wasWrite;
    next_latchData = latchData;
    next_latchAddr = latchAddr;
    next_wrValid = 1'b0;
    next_rdStrobe = 1'b0;
    next_devData = bus.devData;
    next_devDataOe = 1'b0;
    next_waitOut = 1'b1;
    next_waitOe = 1'b0;
    unique case (state)
      LHP_IDLE:
      begin
        if (active)
        begin
          next_state = LHP_HOLD;
          next_cnt = lhp_pkg::WAIT_COUNT;
          next_wasWrite = isWrite;
          next_latchAddr = addrS2;
          next_rdStrobe = !isWrite;
          // Generic waits low, address-strobe acknowledge waits high.
          next_waitOe = (style != lhp_pkg::STYLE_ENABLE_CLOCKED);
          next_waitOut = (style == lhp_pkg::STYLE_ADDR_STROBE);
        end
      end
      LHP_HOLD:
      begin
        next_waitOe = (style != lhp_pkg::STYLE_ENABLE_CLOCKED);
        next_devDataOe = !wasWrite && active;
        if (!wasWrite)
          next_devData = rdData;
        if (wasWrite)
          next_latchData = dataS2;
        if (cnt != '0)
        begin
          next_cnt = cnt - CNT_ONE;
          next_waitOut = (style == lhp_pkg::STYLE_ADDR_STROBE);
        end
        else
        begin
          // Completion level; held until the strobe ends.
          next_waitOut = (style != lhp_pkg::STYLE_ADDR_STROBE);
          if (!active)
          begin
            // A write in any style commits when the strobe end is seen, with data sampled in that same cycle.
            next_wrValid = wasWrite;
            next_state = LHP_DONE;
          end
        end
      end
      LHP_DONE:
      begin
        next_state = LHP_IDLE;
      end
      default:
        next_state = LHP_IDLE;
    endcase
  end

  // State registers; wait output released and data drivers off at reset.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= LHP_IDLE;
      cnt <= '0;
      wasWrite <= 1'b0;
      latchData <= lhp_pkg::DATA_RESET;
      latchAddr <= '0;
      wrValid <= 1'b0;
      rdStrobe <= 1'b0;
      bus.devData <= lhp_pkg::DATA_RESET;
      bus.devDataOe <= 1'b0;
      bus.waitOut <= 1'b1;
      bus.waitOe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wasWrite <= next_wasWrite;
      latchData <= next_latchData;
      latchAddr <= next_latchAddr;
      wrValid <= next_wrValid;
      rdStrobe <= next_rdStrobe;
      bus.devData <= next_devData;
      bus.devDataOe <= next_devDataOe;
      bus.waitOut <= next_waitOut;
      bus.waitOe <= next_waitOe;
    end
  end

  // Write data is the sample taken in the cycle in which the end of the strobe is seen.
  assign wrData = latchData;
  assign wrAddr = latchAddr;
  assign rdAddr = latchAddr;

endmodule // lhp_device

// File: lhp_host.sv
`timescale 1ns/10ps
module lhp_host (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host bus pins.
  lhp_bus_if.host bus,
  // Configuration.
  input wire logic [1:0] styleSel,
  input wire logic indirectSel,
  // Command port.
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [lhp_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [lhp_pkg::DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic [lhp_pkg::DATA_W-1:0] respData,
  output logic respValid
);

  typedef enum logic [1:0] {
    LHP_H_IDLE = 2'b00,
    LHP_H_STROBE = 2'b01,
    LHP_H_END = 2'b10
  } lhp_host_state_e;

  // Wait line from the device passes two flops.
  logic waitS1, waitS2;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      waitS1 <= 1'b1;
      waitS2 <= 1'b1;
    end
    else
    begin
      waitS1 <= bus.waitLine;
      waitS2 <= waitS1;
    end
  end

  // Completion as seen per style; enable-clocked has no handshake.
  logic complete;
  always_comb
  begin
    complete = 1'b0;
    if (styleSel == lhp_pkg::STYLE_GENERIC)
      complete = waitS2;
    else if (styleSel == lhp_pkg::STYLE_ADDR_STROBE)
      complete = !waitS2;
    else
      complete = 1'b0;
  end

  // Decrement step at the counter's own width, so nothing is padded.
  localparam logic [lhp_pkg::CNT_W-1:0] CNT_ONE =
    {{(lhp_pkg::CNT_W-1){1'b0}}, 1'b1};

  lhp_host_state_e state, next_state;
  logic [lhp_pkg::CNT_W-1:0] cnt, next_cnt;
  logic isWr, next_isWr;
  logic [lhp_pkg::DATA_W-1:0] next_respData;
  logic next_respValid, strobeOn, next_strobeOn;
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_isWr = isWr;
    next_respData = respData;
    next_respValid = 1'b0;
    next_strobeOn = strobeOn;
    unique case (state)
      LHP_H_IDLE:
        if (cmdValid)
        begin
          next_state = LHP_H_STROBE;
          next_isWr = cmdWrite;
          next_strobeOn = 1'b1;
          next_cnt = lhp_pkg::STROBE_COUNT + lhp_pkg::WAIT_COUNT;
        end
      LHP_H_STROBE:
      begin
        // Hold strobe for minimum time, then until the handshake completes.
        if (cnt != '0)
          next_cnt = cnt - CNT_ONE;
        else if (complete || styleSel == lhp_pkg::STYLE_ENABLE_CLOCKED)
        begin
          next_respData = bus.busData;
          next_respValid = !isWr;
          next_strobeOn = 1'b0;
          next_state = LHP_H_END;
          next_cnt = lhp_pkg::STROBE_COUNT;
        end
      end
      LHP_H_END:
        if (cnt != '0)
          next_cnt = cnt - CNT_ONE;
        else
          next_state = LHP_H_IDLE;
      default:
        next_state = LHP_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= LHP_H_IDLE;
      cnt <= '0;
      isWr <= 1'b0;
      respData <= lhp_pkg::DATA_RESET;
      respValid <= 1'b0;
      strobeOn <= 1'b0;
      bus.addr <= '0;
      bus.hostData <= lhp_pkg::DATA_RESET;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      isWr <= next_isWr;
      respData <= next_respData;
      respValid <= next_respValid;
      strobeOn <= next_strobeOn;
      if (state == LHP_H_IDLE && cmdValid)
      begin
        bus.addr <= cmdAddr;
        bus.hostData <= cmdData;
      end
    end
  end

  // Pin drive per bus style; straps held static from configuration.
  logic busy;
  assign busy = (state != LHP_H_IDLE);
  assign cmdReady = !busy;
  assign bus.bus_style_straps = styleSel;
  assign bus.addressing_mode_strap = indirectSel;
  assign bus.chipSelect_n = !busy;
  assign bus.hostDataOe = busy && isWr;
  always_comb
  begin
    bus.readPin = 1'b1;
    bus.writePin = 1'b1;
    bus.addr_strobe_n = 1'b1;
    unique case (styleSel)
      lhp_pkg::STYLE_ENABLE_CLOCKED:
      begin
        bus.readPin = strobeOn;
        bus.writePin = !(busy && isWr);
      end
      lhp_pkg::STYLE_ADDR_STROBE:
      begin
        bus.addr_strobe_n = !strobeOn;
        bus.readPin = !strobeOn;
        bus.writePin = !(busy && isWr);
      end
      default:
      begin
        bus.readPin = !(strobeOn && !isWr);
        bus.writePin = !(strobeOn && isWr);
      end
    endcase
  end

endmodule // lhp_host

// File: lhp_pkg.sv
package lhp_pkg;

  // Bus style codes carried on the two bus style straps.
  localparam logic [1:0] STYLE_GENERIC = 2'h0;
  localparam logic [1:0] STYLE_ENABLE_CLOCKED = 2'h1;
  localparam logic [1:0] STYLE_ADDR_STROBE = 2'h2;

  // Addressing mode strap values.
  localparam logic MODE_DIRECT = 1'h0;
  localparam logic MODE_INDIRECT = 1'h1;

  // Bus widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 1;

  // Clock period and strobe timing in ns; counts derive from them.
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAIT_TIME_NS = 16;
  localparam int WAIT_CYCLES =
    (WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_TIME_NS = 16;
  localparam int STROBE_CYCLES =
    (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] WAIT_COUNT = CNT_W'(WAIT_CYCLES);
  localparam logic [CNT_W-1:0] STROBE_COUNT = CNT_W'(STROBE_CYCLES);

  // Reset value of the data register.
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

endpackage
